// ==== verilog/nvp_pkg.sv ====
/*
  Package for the nonvolatile clock and EEPROM paging block: register map,
  field positions, reset values, sizes and the structs on its ports.
  Assumes a 32-bit AXI4-Lite register bus and an 8-bit register file.
*/
`default_nettype none
package nvp_pkg;
  // Bus and map sizes
  localparam int unsigned AXI_AW   = 12;
  localparam int unsigned FG_AW    = 10;          // foreground EEPROM window
  localparam int unsigned PH_AW    = 11;          // whole EEPROM array
  localparam int unsigned SEC_AW   = 8;           // 8-byte sectors in array
  localparam int unsigned PULSE_W  = 16;
  // Register byte offsets
  localparam logic [AXI_AW-1:0] OFS_CLKDIV = 12'h000;
  localparam logic [AXI_AW-1:0] OFS_CONFIG = 12'h004;
  localparam logic [AXI_AW-1:0] OFS_OPTION = 12'h008;
  localparam logic [AXI_AW-1:0] OFS_STATUS = 12'h00c;
  // Field positions
  localparam int unsigned BIT_LOADED   = 7;       // clock divider
  localparam int unsigned BIT_PRESCALE = 6;
  localparam int unsigned BIT_PAGE_SEL = 6;       // config
  localparam int unsigned BIT_SEC_MODE = 5;       // option
  localparam int unsigned BIT_BUSY     = 0;       // status
  localparam int unsigned BIT_REFUSED  = 1;
  // Reset values and constants
  localparam logic [6:0] CLKDIV_RST   = 7'h00;
  localparam logic [2:0] PRESCALE_MAX = 3'h7;     // divide by 8
  localparam logic [7:0] ERASE_ALL    = 8'hff;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  // EEPROM access toward the array
  typedef struct packed {
    logic             valid;
    logic             write;
    logic [PH_AW-1:0] addr;
  } nvp_access_t;

  // Sector erase toward the array
  typedef struct packed {
    logic              valid;
    logic [SEC_AW-1:0] sector;
    logic [7:0]        byte_mask;
  } nvp_erase_t;
endpackage
`default_nettype wire

// ==== verilog/nvp_top.sv ====
/*
  Nonvolatile clock divider with write-once setup, operation gate and
  pulse timer, plus EEPROM page mapping and sector erase scope.
  Assumes one 200 MHz clock, a synchronous reset, and that the option byte
  input is stable while reset is held.
*/
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
// What this block does
// - Only one half of the EEPROM array is reachable through the memory map at any time.
// - The page-select bit picks which half is foreground and reachable.
// - Two sector mapping modes, 4-byte and 8-byte, chosen by the sector-mode bit.
// - With sector mode 0 each 8-byte sector has four bytes per page at the same addresses.
// - In 4-byte mode a sector erase clears all eight bytes of the sector.
// - With sector mode 1 each whole 8-byte sector lies in one page.
// - In 8-byte mode a sector erase clears only the addressed foreground sector.
// - The loaded flag in bit 7 clears at reset and sets on the first divider write.
// - Divider bits 6..0 are always readable and take only the first write after reset.
// - Erase and program operations are refused until the loaded flag is set.
// - The prescale bit feeds the divider with the bus clock over 8, else undivided.
// - The prescaler output is divided by the 6-bit divisor plus one.
// - Each timing pulse lasts exactly one period of the timing clock.
// - Each operation is timed as a whole number of timing pulses.
// - The working option register is loaded from the option byte during reset.
`timescale 1ns/1ps
`default_nettype none
module nvp_top (
  // Clock and reset
  input  wire logic                          i_clk_sys,
  input  wire logic                          i_srst,
  // AXI4-Lite write channels
  input  wire logic [nvp_pkg::AXI_AW-1:0]    i_awaddr,
  input  wire logic                          i_awvalid,
  output logic                               o_awready,
  input  wire logic [31:0]                   i_wdata,
  input  wire logic [3:0]                    i_wstrb,
  input  wire logic                          i_wvalid,
  output logic                               o_wready,
  output logic [1:0]                         o_bresp,
  output logic                               o_bvalid,
  input  wire logic                          i_bready,
  // AXI4-Lite read channels
  input  wire logic [nvp_pkg::AXI_AW-1:0]    i_araddr,
  input  wire logic                          i_arvalid,
  output logic                               o_arready,
  output logic [31:0]                        o_rdata,
  output logic [1:0]                         o_rresp,
  output logic                               o_rvalid,
  input  wire logic                          i_rready,
  // Option byte from flash
  input  wire logic [7:0]                    i_option_byte,
  // CPU access to the EEPROM window
  input  wire logic                          i_ee_req,
  input  wire logic                          i_ee_write,
  input  wire logic [nvp_pkg::FG_AW-1:0]     i_ee_addr,
  output nvp_pkg::nvp_access_t               o_ee_access,
  // Sector erase request from the sequencer
  input  wire logic                          i_erase_req,
  input  wire logic [nvp_pkg::FG_AW-1:0]     i_erase_addr,
  output nvp_pkg::nvp_erase_t                o_erase,
  // Operation start and timing toward the sequencer
  input  wire logic                          i_op_start,
  input  wire logic [nvp_pkg::PULSE_W-1:0]   i_op_pulses,
  output logic                               o_op_refused,
  output logic                               o_op_busy,
  output logic                               o_op_done,
  output logic                               o_nvm_tick
);
  import nvp_pkg::*;

  logic                   loaded_q;
  logic [6:0]             clkdiv_q;
  logic                   page_sel_q;
  logic [7:0]             option_q;
  logic                   refused_q;
  logic [AXI_AW-1:0]      awaddr_q;
  logic [31:0]            wdata_q;
  logic [3:0]             wstrb_q;
  logic                   aw_held_q;
  logic                   w_held_q;
  logic                   do_write;
  logic                   wr_clkdiv;
  logic                   wr_config;
  logic                   wr_status;
  logic                   wr_mapped;
  logic [2:0]             pre_q;
  logic                   pre_en;
  logic [5:0]             div_q;
  logic                   tick;
  logic [PULSE_W-1:0]     remain_q;
  logic                   sec_mode;
  logic                   op_refuse;
  logic [31:0]            rd_word;
  logic                   rd_mapped;

  assign sec_mode = option_q[BIT_SEC_MODE];

  // Write decode; a write fires once address and data are both held
  assign do_write  = aw_held_q && w_held_q && !o_bvalid;
  assign wr_clkdiv = do_write && (awaddr_q == OFS_CLKDIV);
  assign wr_config = do_write && (awaddr_q == OFS_CONFIG);
  assign wr_status = do_write && (awaddr_q == OFS_STATUS);
  assign wr_mapped = wr_clkdiv || wr_config || wr_status || (awaddr_q == OFS_OPTION);

  // Address and data channels taken in either order, one write in flight
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
    end else begin
      o_awready <= !aw_held_q && !(o_awready && i_awvalid);
      o_wready  <= !w_held_q && !(o_wready && i_wvalid);
      if (o_awready && i_awvalid) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= i_awaddr;
      end else if (do_write) begin
        aw_held_q <= 1'b0;
      end
      if (o_wready && i_wvalid) begin
        w_held_q <= 1'b1;
        wdata_q  <= i_wdata;
        wstrb_q  <= i_wstrb;
      end else if (do_write) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Write response; unmapped offsets answer with a slave error
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_bvalid <= 1'b0;
      o_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      o_bvalid <= 1'b1;
      o_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // Divider register is write once so runaway code cannot retime pulses
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      loaded_q <= 1'b0;
      clkdiv_q <= CLKDIV_RST;
    end else if (wr_clkdiv && !loaded_q) begin
      loaded_q <= 1'b1;
      if (wstrb_q[0]) begin
        clkdiv_q <= wdata_q[6:0];
      end
    end
  end

  // Page select, freely writable by software
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      page_sel_q <= 1'b0;
    end else if (wr_config && wstrb_q[0]) begin
      page_sel_q <= wdata_q[BIT_PAGE_SEL];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      option_q <= i_option_byte;
    end
  end

  // Refused flag is sticky; a new refusal beats a clear in the same cycle
  assign op_refuse = i_op_start && !loaded_q;
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      refused_q <= 1'b0;
    end else if (op_refuse) begin
      refused_q <= 1'b1;
    end else if (wr_status && wstrb_q[0] && wdata_q[BIT_REFUSED]) begin
      refused_q <= 1'b0;
    end
  end

  // Read mux; reserved bits read as zero
  always_comb begin
    rd_word   = '0;
    rd_mapped = 1'b1;
    unique case (i_araddr)
      OFS_CLKDIV: rd_word[7:0] = {loaded_q, clkdiv_q};
      OFS_CONFIG: rd_word[BIT_PAGE_SEL] = page_sel_q;
      OFS_OPTION: rd_word[7:0] = option_q;
      OFS_STATUS: begin
        rd_word[BIT_BUSY]    = o_op_busy;
        rd_word[BIT_REFUSED] = refused_q;
      end
      default: rd_mapped = 1'b0;
    endcase
  end

  // Read channel, data one cycle after the address is taken
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= '0;
      o_rresp   <= RESP_OKAY;
    end else begin
      o_arready <= !o_rvalid && !(o_arready && i_arvalid);
      if (o_arready && i_arvalid) begin
        o_rvalid <= 1'b1;
        o_rdata  <= rd_word;
        o_rresp  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  assign pre_en = !clkdiv_q[BIT_PRESCALE] || (pre_q == PRESCALE_MAX);
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || !loaded_q) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 3'h1;
    end
  end

  assign tick = loaded_q && pre_en && (div_q == clkdiv_q[5:0]);
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || !loaded_q) begin
      div_q <= '0;
    end else if (tick) begin
      div_q <= '0;
    end else if (pre_en) begin
      div_q <= div_q + 6'h01;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_nvm_tick <= 1'b0;
    end else begin
      o_nvm_tick <= tick;
    end
  end

  // Operation timer; a zero count still takes one whole pulse
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_op_busy    <= 1'b0;
      o_op_done    <= 1'b0;
      o_op_refused <= 1'b0;
      remain_q     <= '0;
    end else begin
      o_op_done    <= 1'b0;
      o_op_refused <= op_refuse;
      if (i_op_start && loaded_q && !o_op_busy) begin
        o_op_busy <= 1'b1;
        remain_q  <= i_op_pulses;
      end else if (o_op_busy && tick) begin
        if (remain_q <= 16'h0001) begin
          o_op_busy <= 1'b0;
          o_op_done <= 1'b1;
        end else begin
          remain_q <= remain_q - 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_ee_access <= '0;
    end else begin
      o_ee_access.valid <= i_ee_req;
      o_ee_access.write <= i_ee_write;
      if (sec_mode) begin
        o_ee_access.addr <= {page_sel_q, i_ee_addr};
      end else begin
        o_ee_access.addr <= {i_ee_addr[FG_AW-1:2], page_sel_q, i_ee_addr[1:0]};
      end
    end
  end

  // Erase scope; refused erases never reach the array
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_erase <= '0;
    end else begin
      o_erase.valid     <= i_erase_req && loaded_q;
      o_erase.byte_mask <= ERASE_ALL;
      if (sec_mode) begin
        o_erase.sector <= {page_sel_q, i_erase_addr[FG_AW-1:3]};
      end else begin
        o_erase.sector <= i_erase_addr[FG_AW-1:2];
      end
    end
  end
endmodule // nvp_top
`default_nettype wire

// ==== test/nvp_chk.sv ====
/* Checker for nvp_top: operation gate, tick period, EEPROM map, erase scope.
   Sees only top ports; bound from the testbench. */
`timescale 1ns/1ps
`default_nettype none
module nvp_chk (
  // Clock, reset and write bus
  input wire logic                        i_clk_sys,
  input wire logic                        i_srst,
  input wire logic [nvp_pkg::AXI_AW-1:0]  i_awaddr,
  input wire logic                        i_awvalid,
  input wire logic                        o_awready,
  input wire logic [31:0]                 i_wdata,
  // Paging, erase and operations
  input wire logic [7:0]                  i_option_byte,
  input wire logic                        i_ee_req,
  input wire logic                        i_ee_write,
  input wire logic [nvp_pkg::FG_AW-1:0]   i_ee_addr,
  input wire nvp_pkg::nvp_access_t        o_ee_access,
  input wire logic                        i_erase_req,
  input wire logic [nvp_pkg::FG_AW-1:0]   i_erase_addr,
  input wire nvp_pkg::nvp_erase_t         o_erase,
  input wire logic                        i_op_start,
  input wire logic                        o_op_refused,
  input wire logic                        o_op_busy,
  input wire logic                        o_nvm_tick
);
  import nvp_pkg::*;
  logic ld_q, ld2_q, page_q, page2_q, mode_q, seen_q, aw_take;
  logic [9:0] per_q, cnt_q;
  logic [PH_AW-1:0] ee_exp;
  logic [SEC_AW-1:0] sec_exp;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  assign aw_take = i_awvalid && o_awready;
  // Divider load and page select; ld2_q sets on the same edge as the register update
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      ld_q <= 1'b0;
      ld2_q <= 1'b0;
      page_q <= 1'b0;
      page2_q <= 1'b0;
    end else begin
      ld2_q <= ld_q;
      // Page bit lands one edge after the address is taken, as the divider does
      page2_q <= page_q;
      if (aw_take && i_awaddr == OFS_CLKDIV && !ld_q) begin
        ld_q <= 1'b1;
        per_q <= (i_wdata[6] ? 10'h8 : 10'h1) * ({4'h0, i_wdata[5:0]} + 10'h1);
      end
      if (aw_take && i_awaddr == OFS_CONFIG) page_q <= i_wdata[BIT_PAGE_SEL];
    end
  end
  // Sector mode follows the option byte while reset is held
  always_ff @(posedge i_clk_sys) if (i_srst) mode_q <= i_option_byte[BIT_SEC_MODE];
  // Cycles between ticks; first interval skipped, its phase is free
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      cnt_q <= 10'h0;
      seen_q <= 1'b0;
    end else begin
      cnt_q <= o_nvm_tick ? 10'h1 : cnt_q + 10'h1;
      seen_q <= seen_q | o_nvm_tick;
    end
  end
  assign ee_exp = mode_q ? {page2_q, i_ee_addr} : {i_ee_addr[9:2], page2_q, i_ee_addr[1:0]};
  assign sec_exp = mode_q ? {page2_q, i_erase_addr[9:3]} : i_erase_addr[9:2];
  sequence s_cold_start;
    i_op_start && !ld_q && !o_op_busy;
  endsequence
  sequence s_warm_start;
    i_op_start && ld2_q && !o_op_busy;
  endsequence
  AST_OP_REFUSE: assert property (s_cold_start |=> o_op_refused)
    else $error("start not refused before load");
  AST_REFUSE_CAUSE: assert property (o_op_refused |-> $past(i_op_start))
    else $error("refusal without a start");
  AST_OP_TAKEN: assert property (s_warm_start |=> o_op_busy && !o_op_refused)
    else $error("loaded start not taken");
  AST_TICK_PERIOD: assert property (o_nvm_tick && seen_q |-> cnt_q == per_q)
    else $error("tick period wrong");
  AST_TICK_GATE: assert property (!ld_q |-> !o_nvm_tick)
    else $error("tick before divider load");
  AST_EE_MAP: assert property (i_ee_req |=> o_ee_access.valid
    && o_ee_access.addr == $past(ee_exp) && o_ee_access.write == $past(i_ee_write))
    else $error("eeprom address map wrong");
  AST_ERASE_SCOPE: assert property (i_erase_req && ld2_q |=> o_erase.valid
    && o_erase.sector == $past(sec_exp) && o_erase.byte_mask == 8'hff)
    else $error("erase scope wrong");
  AST_ERASE_GATE: assert property (i_erase_req && !ld_q |=> !o_erase.valid)
    else $error("erase before divider load");
endmodule // nvp_chk
`default_nettype wire

// ==== test/nvp_seq_model.sv ====
/* Sequencer model: launches timed operations and measures their length.
   Assumes go is a one-cycle pulse from the bench. */
`timescale 1ns/1ps
`default_nettype none
module nvp_seq_model (
  input wire logic         i_clk_sys,
  input wire logic         i_go,
  input wire logic [15:0]  i_n,
  input wire logic         i_busy,
  input wire logic         i_done,
  output logic             o_start,
  output logic [15:0]      o_pulses,
  output logic [31:0]      o_cycles,
  output logic             o_fin
);
  always @(posedge i_clk_sys) begin
    o_start <= i_go;
    if (i_go) begin
      o_pulses <= i_n;
      o_cycles <= 32'h0;
      o_fin <= 1'b0;
    end else if (i_done) o_fin <= 1'b1;
    else if (i_busy) o_cycles <= o_cycles + 32'h1;
  end
endmodule // nvp_seq_model
`default_nettype wire

// ==== test/tb_nvp_clock_and_eeprom_paging.sv ====
/* Testbench for nvp_top: registers over AXI4-Lite, paging, erase, timing.
   Assumes the checker and sequencer model files are compiled first. */
`timescale 1ns/1ps
`default_nettype none
bind nvp_top nvp_chk u_chk (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_awaddr(i_awaddr),
  .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata),
  .i_option_byte(i_option_byte), .i_ee_req(i_ee_req), .i_ee_write(i_ee_write),
  .i_ee_addr(i_ee_addr), .o_ee_access(o_ee_access), .i_erase_req(i_erase_req),
  .i_erase_addr(i_erase_addr), .o_erase(o_erase), .i_op_start(i_op_start),
  .o_op_refused(o_op_refused), .o_op_busy(o_op_busy), .o_nvm_tick(o_nvm_tick));
module tb_nvp_clock_and_eeprom_paging;
  import nvp_pkg::*;
  logic clk = 0, srst = 1, awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0, go = 0;
  logic ee_req = 0, ee_wr = 0, er_req = 0, awr, wr_rdy, bv, arr, rv, refd, busy, done, tick;
  logic start, fin;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdat, cyc;
  logic [3:0] ws = 4'hf;
  logic [7:0] opt = 8'h0, cfg;
  logic [9:0] ee_a = 0, er_a = 0;
  logic [15:0] n = 0, pul;
  logic [1:0] br, rr;
  nvp_access_t acc;
  nvp_erase_t ers;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  logic [28:0] eq[$];
  logic [28:0] eseen;
  int miscompares = 0, comparisons = 0, per;
  always #2.5 clk = ~clk;
  nvp_top u_dut (.i_clk_sys(clk), .i_srst(srst), .i_awaddr(awa), .i_awvalid(awv),
    .o_awready(awr), .i_wdata(wd), .i_wstrb(ws), .i_wvalid(wv), .o_wready(wr_rdy),
    .o_bresp(br), .o_bvalid(bv), .i_bready(brdy), .i_araddr(ara), .i_arvalid(arv),
    .o_arready(arr), .o_rdata(rdat), .o_rresp(rr), .o_rvalid(rv), .i_rready(rrdy),
    .i_option_byte(opt), .i_ee_req(ee_req), .i_ee_write(ee_wr), .i_ee_addr(ee_a),
    .o_ee_access(acc), .i_erase_req(er_req), .i_erase_addr(er_a), .o_erase(ers),
    .i_op_start(start), .i_op_pulses(pul), .o_op_refused(refd), .o_op_busy(busy),
    .o_op_done(done), .o_nvm_tick(tick));
  nvp_seq_model u_seq (.i_clk_sys(clk), .i_go(go), .i_n(n), .i_busy(busy), .i_done(done),
    .o_start(start), .o_pulses(pul), .o_cycles(cyc), .o_fin(fin));
  // Array side as seen; erase fields only count while the erase is valid
  assign eseen = {acc.write, acc.addr, ers.valid, ers.valid ? {ers.sector, ers.byte_mask} : 16'h0};
  task automatic end_of_test();
    if (miscompares == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    bq.push_back(e);
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    brdy <= 1;
    do begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wr_rdy) wv <= 0;
    end while (!bv);
    brdy <= 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    rq.push_back({e, d});
    @(posedge clk);
    ara <= a;
    arv <= 1;
    rrdy <= 1;
    do begin
      @(posedge clk);
      if (arr) arv <= 0;
    end while (!rv);
    rrdy <= 0;
  endtask
  // Random foreground accesses and erase requests, back to back; each noted
  // with the physical address and erase scope that page and mode call for
  task automatic burst(input logic pg, input logic ld);
    logic w, er;
    logic [9:0] a, ea;
    logic [7:0] sec;
    repeat (16) begin
      w = 1'($urandom);
      a = 10'($urandom);
      er = 1'($urandom);
      ea = 10'($urandom);
      sec = opt[BIT_SEC_MODE] ? {pg, ea[9:3]} : ea[9:2];
      eq.push_back({w, opt[BIT_SEC_MODE] ? {pg, a} : {a[9:2], pg, a[1:0]}, er && ld,
        (er && ld) ? {sec, 8'hff} : 16'h0});
      @(posedge clk);
      ee_req <= 1;
      ee_wr <= w;
      ee_a <= a;
      er_req <= er;
      er_a <= ea;
    end
    @(posedge clk);
    ee_req <= 0;
    er_req <= 0;
    repeat (3) @(posedge clk);
    // Every noted access must have come out on the array side
    chk(34'(eq.size()), 34'h0);
  endtask
  task automatic op(input logic [15:0] c);
    int nn;
    nn = (c == 0) ? 1 : int'(c);
    @(posedge clk);
    go <= 1; n <= c;
    @(posedge clk);
    go <= 0;
    repeat (2) @(posedge clk);
    while (!fin) @(posedge clk);
    chk({33'h0, cyc >= (nn - 1) * per && cyc <= nn * per + 2}, 34'h1);
  endtask
  // Answers compared against the oldest note
  always @(posedge clk) begin
    if (bv && brdy && bq.size() > 0) chk({32'h0, br}, {32'h0, bq.pop_front()});
    if (rv && rrdy && rq.size() > 0) chk({rr, rdat}, rq.pop_front());
    if (acc.valid && eq.size() > 0) chk({5'h0, eseen}, {5'h0, eq.pop_front()});
  end
  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    end_of_test();
  end
  initial begin
    void'($urandom(36));
    for (int m = 0; m < 2; m++) begin
      // settings chosen by software; both prescale choices
      cfg = m ? 8'h05 : 8'h42;
      per = m ? 6 : 24;
      srst <= 1; opt <= m ? 8'h20 : 8'h00;
      repeat (6) @(posedge clk);
      srst <= 0;
      rd(OFS_CLKDIV, 32'h0, RESP_OKAY);
      rd(OFS_OPTION, {24'h0, opt}, RESP_OKAY);
      burst(1'b0, 1'b0);
      // Start while the divider is unloaded must be refused
      @(posedge clk);
      go <= 1;
      @(posedge clk);
      go <= 0;
      repeat (3) @(posedge clk);
      rd(OFS_STATUS, 32'h2, RESP_OKAY);
      wr(OFS_STATUS, 32'h2, RESP_OKAY);
      rd(OFS_STATUS, 32'h0, RESP_OKAY);
      wr(OFS_CLKDIV, {24'h0, cfg}, RESP_OKAY);
      wr(OFS_CLKDIV, 32'h3f, RESP_OKAY);
      rd(OFS_CLKDIV, {24'h0, 1'b1, cfg[6:0]}, RESP_OKAY);
      wr(12'h010, 32'h1, RESP_SLVERR);
      rd(12'h010, 32'h0, RESP_SLVERR);
      burst(1'b0, 1'b1);
      wr(OFS_CONFIG, 32'h40, RESP_OKAY);
      rd(OFS_CONFIG, 32'h40, RESP_OKAY);
      burst(1'b1, 1'b1);
      op(16'h0);
      op(16'h3);
    end
    end_of_test();
  end
endmodule // tb_nvp_clock_and_eeprom_paging
`default_nettype wire
